// [include/cbpsc_pkg.sv]
// Constants, register map and state type for the cell balancing pause/stop control.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register port.
package cbpsc_pkg;
    localparam int          NUM_CH       = 6;
    localparam int          TIME_W       = 7;
    localparam int          THR_W        = 8;
    localparam int          OT_THR_W     = 4;
    localparam int          ADDR_W       = 6;

    // Register byte offsets
    localparam logic [5:0]  ADDR_CTRL    = 6'h00;
    localparam logic [5:0]  ADDR_STAT    = 6'h04;
    localparam logic [5:0]  ADDR_DONE    = 6'h08;
    localparam logic [5:0]  ADDR_OT_THR  = 6'h0C;
    localparam logic [5:0]  ADDR_RESULT  = 6'h10;
    localparam logic [5:0]  ADDR_CH_BASE = 6'h20;

    // Control register fields
    localparam int          CTRL_GO      = 0;
    localparam int          CTRL_PAUSE   = 1;
    localparam int          CTRL_OT_EN   = 2;
    localparam int          CTRL_FLT_EN  = 3;
    localparam int          CTRL_ACT_LSB = 4;
    localparam int          CTRL_LATCH   = 8;
    localparam int          CTRL_SEL_LSB = 12;

    // Status register fields
    localparam int          STAT_RUN     = 0;
    localparam int          STAT_PAUSED  = 1;
    localparam int          STAT_DONE    = 2;
    localparam int          STAT_ABORT   = 3;
    localparam int          STAT_VALID   = 4;

    // Values
    localparam logic [1:0]  POWER_SHUTDOWN = 2'h2;
    localparam logic [7:0]  RESULT_INVALID = 8'hFF;
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;

    // Countdown unit: one timer step per TIME_LSB_MS milliseconds
    localparam int unsigned TIME_LSB_MS  = 1000;
    localparam int unsigned CLK_KHZ      = 200000;
    localparam int unsigned TICK_CYCLES  = TIME_LSB_MS * CLK_KHZ;

    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_DONE, ST_ABORT} cbpsc_state_type;

    // Channel number of a per-channel timer address, NUM_CH when out of range
    function automatic logic [3:0] ch_index(input logic [5:0] addr);
        logic [5:0] rel;
        rel = addr - ADDR_CH_BASE;
        if (addr >= ADDR_CH_BASE && rel[5:2] < NUM_CH) begin
            ch_index = rel[5:2];
        end else begin
            ch_index = 4'(NUM_CH);
        end
    endfunction
endpackage

// [core/cbpsc_chan_timer.sv]
// One balancing channel: countdown timer and per-channel stop logic.
// Assumes load, tick, hold and abort come from the same clock domain.
`timescale 1ns/10ps
module cbpsc_chan_timer #(
    parameter int W = 7
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         tick,
    input  wire logic         hold,
    input  wire logic         below_done,
    input  wire logic         abort,
    output logic      [W-1:0] count,
    output logic              active
);
    logic [W-1:0] count_reg;
    logic         active_reg;

    // Countdown; frozen while held, stopped channels keep what is left
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_value;
        end else if (active_reg && tick && !hold && count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    // Channel stays active while time is left and no stop condition hit
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            active_reg <= 1'b0;
        end else if (load) begin
            active_reg <= (load_value != '0);
        end else if (abort) begin
            active_reg <= 1'b0;
        end else if (active_reg && !hold) begin
            if (below_done || (tick && count_reg == W'(1)) || count_reg == '0) begin
                active_reg <= 1'b0;
            end
        end
    end

    assign count  = count_reg;
    assign active = active_reg;

    a_timer_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hold && !load |=> $stable(count_reg)) else $error("timer moved while held");
    a_stop_expire: assert property (@(posedge clk_sys) disable iff (!rst_b)
        active_reg && tick && !hold && !load && count_reg == W'(1) |=> !active_reg && count_reg == '0)
        else $error("channel kept running after expiry");
endmodule

// [core/cbpsc_top.sv]
// Cell balancing pause/stop control with Avalon-MM register slave.
// Assumes protector comparator results arrive as asynchronous pins.
//
// Summary of operation
// - Balancing started in active mode keeps running after the device enters sleep.
// - On completion the device requests the configured power mode; 0b10 is shutdown.
// - Pause on die overheat, enabled thermistor overheat, or host pause request.
// - Host may set the pause request any time after start; honoured immediately.
// - While paused all switches are off, timers frozen, paused flag set.
// - An unmasked fault during pause never aborts balancing.
// - On leaving pause, timers resume and channels with time left rebalance.
// - A channel stops on timer expiry or voltage below a non-zero done threshold.
// - Complete flag sets only when every enabled channel has stopped normally.
// - With fault abort enabled, a fault stops all channels and sets the abort flag.
// - Go with every timer zero starts nothing and leaves complete clear.
// - Go with time set but all cells below threshold starts, stops, completes.
// - Six per-channel timers load on start, count down, and hold in pause.
// - Latch command copies the selected channel's remaining time to the result.
// - Latched time is meaningful only when running, paused or validly stopped.
// - With balancing held stopped, the remaining time reads an invalid code.
// - Expiry stop reads zero; done-voltage stop reads the time still left.
// - Writing go starts balancing; running flag is high while actively balancing.
// - Pause leaves all balancing settings untouched for the resume.
`timescale 1ns/10ps
module cbpsc_top
    import cbpsc_pkg::*;
#(
    parameter int unsigned TICK_CYC = cbpsc_pkg::TICK_CYCLES
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    input  wire logic [cbpsc_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic                          die_temp_hot,
    input  wire logic                          thermistor_hot,
    input  wire logic                          fault_unmasked,
    input  wire logic [cbpsc_pkg::NUM_CH-1:0]  cell_below_done,
    output logic      [cbpsc_pkg::NUM_CH-1:0]  balance_switch,
    output logic      [cbpsc_pkg::THR_W-1:0]   done_voltage_threshold,
    output logic      [cbpsc_pkg::OT_THR_W-1:0] thermistor_pause_threshold,
    output logic      [1:0]                    power_mode_request,
    output logic                               power_mode_strobe
);
    import cbpsc_pkg::*;

    localparam int SW = NUM_CH + 3;

    cbpsc_state_type     state_reg;
    logic [31:0]         rdata_reg;
    logic                wait_reg;
    logic                host_pause_request;
    logic                thermistor_pause_enable;
    logic                fault_abort_enable;
    logic [1:0]          completion_power_action;
    logic [3:0]          remaining_time_channel_select;
    logic [THR_W-1:0]    done_thr_reg;
    logic [OT_THR_W-1:0] ot_thr_reg;
    logic [TIME_W-1:0]   channel_balance_time [NUM_CH];
    logic [7:0]          remaining_time_result;
    logic                balancing_complete_flag;
    logic                fault_abort_flag;
    logic                valid_reg;
    logic [NUM_CH-1:0]   sw_reg;
    logic [1:0]          pwr_req_reg;
    logic                pwr_stb_reg;
    logic [SW-1:0]       sync1_reg;
    logic [SW-1:0]       sync2_reg;
    logic [SW-1:0]       sync3_reg;
    logic [SW-1:0]       filt_reg;
    logic [31:0]         tick_cnt_reg;
    logic                tick;
    logic [TIME_W-1:0]   count    [NUM_CH];
    logic [NUM_CH-1:0]   active;
    logic                acc;
    logic                wr_ctrl;
    logic                go;
    logic                latch;
    logic                all_zero;
    logic                pause_cond;
    logic                die_hot_s;
    logic                ot_hot_s;
    logic                fault_s;
    logic [NUM_CH-1:0]   below_s;
    logic [NUM_CH-1:0]   below_eff;
    logic                paused;
    logic                abort_now;
    logic [3:0]          wr_ch;

    // Bus access is taken on the edge where waitrequest is seen low
    assign acc     = (avs_read || avs_write) && !wait_reg;
    assign wr_ctrl = avs_write && !wait_reg && avs_address == ADDR_CTRL;
    assign go      = wr_ctrl && avs_writedata[CTRL_GO];
    assign latch   = wr_ctrl && avs_writedata[CTRL_LATCH];
    assign wr_ch   = ch_index(avs_address);

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg  <= '0;
        end else begin
            sync1_reg <= {fault_unmasked, thermistor_hot, die_temp_hot, cell_below_done};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
        end
    end

    assign below_s   = filt_reg[NUM_CH-1:0];
    assign die_hot_s = filt_reg[NUM_CH];
    assign ot_hot_s  = filt_reg[NUM_CH+1];
    assign fault_s   = filt_reg[NUM_CH+2];

    // A zero threshold disables the voltage stop
    assign below_eff = (done_thr_reg != '0) ? below_s : '0;

    // Any of the three causes pauses; host bit acts at once
    assign pause_cond = die_hot_s || (thermistor_pause_enable && ot_hot_s) || host_pause_request;
    assign paused     = (state_reg == ST_PAUSE) || (state_reg == ST_RUN && pause_cond);
    assign abort_now  = state_reg == ST_RUN && !pause_cond && fault_abort_enable && fault_s;

    always_comb begin
        all_zero = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (channel_balance_time[i] != '0) begin
                all_zero = 1'b0;
            end
        end
    end

    // Countdown prescaler runs only while balancing, so a pause freezes it
    always_ff @(posedge clk_sys) begin
        if (!rst_b || go) begin
            tick_cnt_reg <= RST_ZERO;
        end else if (state_reg == ST_RUN && !pause_cond) begin
            tick_cnt_reg <= (tick_cnt_reg == TICK_CYC - 1) ? RST_ZERO : tick_cnt_reg + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt_reg == TICK_CYC - 1);

    // One timer per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        cbpsc_chan_timer #(.W(TIME_W)) u_timer (
            .clk_sys    (clk_sys),
            .rst_b      (rst_b),
            .load       (go && !all_zero),
            .load_value (channel_balance_time[g]),
            .tick       (tick),
            .hold       (paused || state_reg != ST_RUN),
            .below_done (below_eff[g]),
            .abort      (abort_now),
            .count      (count[g]),
            .active     (active[g])
        );
    end

    // Settings change only by software writes; pause never touches them
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            host_pause_request            <= 1'b0;
            thermistor_pause_enable       <= 1'b0;
            fault_abort_enable            <= 1'b0;
            completion_power_action       <= 2'h0;
            remaining_time_channel_select <= 4'h0;
            done_thr_reg                  <= '0;
            ot_thr_reg                    <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                channel_balance_time[i] <= '0;
            end
        end else if (avs_write && !wait_reg) begin
            if (avs_address == ADDR_CTRL) begin
                host_pause_request            <= avs_writedata[CTRL_PAUSE];
                thermistor_pause_enable       <= avs_writedata[CTRL_OT_EN];
                fault_abort_enable            <= avs_writedata[CTRL_FLT_EN];
                completion_power_action       <= avs_writedata[CTRL_ACT_LSB +: 2];
                remaining_time_channel_select <= avs_writedata[CTRL_SEL_LSB +: 4];
            end
            if (avs_address == ADDR_DONE) begin
                done_thr_reg <= avs_writedata[THR_W-1:0];
            end
            if (avs_address == ADDR_OT_THR) begin
                ot_thr_reg <= avs_writedata[OT_THR_W-1:0];
            end
            if (wr_ch < NUM_CH) begin
                channel_balance_time[wr_ch[2:0]] <= avs_writedata[TIME_W-1:0];
            end
        end
    end

    // Sequencer; no power-mode input is consulted, so sleep does not stop it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else if (go) begin
            state_reg <= all_zero ? ST_IDLE : ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (pause_cond) begin
                        state_reg <= ST_PAUSE;
                    end else if (abort_now) begin
                        state_reg <= ST_ABORT;
                    end else if (active == '0) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_PAUSE: begin
                    if (!pause_cond) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: state_reg <= state_reg;
            endcase
        end
    end

    // Sticky outcome flags, cleared by the next go
    always_ff @(posedge clk_sys) begin
        if (!rst_b || go) begin
            balancing_complete_flag <= 1'b0;
            fault_abort_flag        <= 1'b0;
        end else if (state_reg == ST_RUN && !pause_cond && !abort_now && active == '0) begin
            balancing_complete_flag <= 1'b1;
        end else if (abort_now) begin
            fault_abort_flag <= 1'b1;
        end
    end

    // Completion requests the chosen power mode with a one-cycle strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pwr_req_reg <= 2'h0;
            pwr_stb_reg <= 1'b0;
        end else begin
            pwr_stb_reg <= 1'b0;
            if (!go && state_reg == ST_RUN && !pause_cond && !abort_now && active == '0) begin
                pwr_req_reg <= completion_power_action;
                pwr_stb_reg <= 1'b1;
            end
        end
    end

    // Switches only while running and not pausing
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sw_reg <= '0;
        end else begin
            sw_reg <= (state_reg == ST_RUN && !pause_cond && !abort_now) ? active : '0;
        end
    end

    // Valid once a real start happened; a go with no time set invalidates it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            valid_reg <= 1'b0;
        end else if (go) begin
            valid_reg <= !all_zero;
        end
    end

    // Latch copies frozen or running count; expiry leaves zero in it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            remaining_time_result <= RESULT_INVALID;
        end else if (latch) begin
            if (!valid_reg || avs_writedata[CTRL_SEL_LSB +: 4] >= NUM_CH) begin
                remaining_time_result <= RESULT_INVALID;
            end else begin
                remaining_time_result <= 8'(count[avs_writedata[CTRL_SEL_LSB +: 3]]);
            end
        end
    end

    // Bus slave: one wait cycle, read data prepared on that edge
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wait_reg  <= 1'b1;
            rdata_reg <= RST_ZERO;
        end else if (acc) begin
            wait_reg <= 1'b1;
        end else if (avs_read || avs_write) begin
            wait_reg  <= 1'b0;
            rdata_reg <= RST_ZERO;
            case (avs_address)
                ADDR_CTRL: begin
                    rdata_reg[CTRL_PAUSE]            <= host_pause_request;
                    rdata_reg[CTRL_OT_EN]            <= thermistor_pause_enable;
                    rdata_reg[CTRL_FLT_EN]           <= fault_abort_enable;
                    rdata_reg[CTRL_ACT_LSB +: 2]     <= completion_power_action;
                    rdata_reg[CTRL_SEL_LSB +: 4]     <= remaining_time_channel_select;
                end
                ADDR_STAT: begin
                    rdata_reg[STAT_RUN]    <= (state_reg == ST_RUN);
                    rdata_reg[STAT_PAUSED] <= (state_reg == ST_PAUSE);
                    rdata_reg[STAT_DONE]   <= balancing_complete_flag;
                    rdata_reg[STAT_ABORT]  <= fault_abort_flag;
                    rdata_reg[STAT_VALID]  <= valid_reg;
                end
                ADDR_DONE:   rdata_reg[THR_W-1:0]    <= done_thr_reg;
                ADDR_OT_THR: rdata_reg[OT_THR_W-1:0] <= ot_thr_reg;
                ADDR_RESULT: rdata_reg[7:0]          <= remaining_time_result;
                default: begin
                    if (wr_ch < NUM_CH) begin
                        rdata_reg[TIME_W-1:0] <= channel_balance_time[wr_ch[2:0]];
                    end
                end
            endcase
        end
    end

    assign avs_readdata               = rdata_reg;
    assign avs_waitrequest            = wait_reg;
    assign balance_switch             = sw_reg;
    assign done_voltage_threshold     = done_thr_reg;
    assign thermistor_pause_threshold = ot_thr_reg;
    assign power_mode_request         = pwr_req_reg;
    assign power_mode_strobe          = pwr_stb_reg;

    a_pause_enter: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == ST_RUN && pause_cond && !go |=> state_reg == ST_PAUSE) else $error("no pause");
    a_pause_switch_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == ST_PAUSE |=> balance_switch == '0) else $error("switch on in pause");
    a_pause_no_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == ST_PAUSE && fault_s && !go |=> !fault_abort_flag) else $error("abort in pause");
    a_pause_resume: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == ST_PAUSE && !pause_cond && !go |=> state_reg == ST_RUN) else $error("no resume");
    a_host_pause_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == ST_PAUSE && host_pause_request && !go |=> state_reg == ST_PAUSE) else $error("left pause");
    a_zero_go_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        go && all_zero |=> state_reg == ST_IDLE && !balancing_complete_flag) else $error("zero go started");
    a_abort_flags: assert property (@(posedge clk_sys) disable iff (!rst_b)
        abort_now && !go |=> fault_abort_flag && !balancing_complete_flag ##1 balance_switch == '0)
        else $error("abort not taken");
    a_done_power: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(balancing_complete_flag) |-> power_mode_strobe && active == '0) else $error("no power request");
    a_invalid_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        latch && !valid_reg |=> remaining_time_result == RESULT_INVALID) else $error("valid code when stopped");
endmodule

// [bench/cbpsc_uv_model.sv]
// Undervoltage protector stand-in: flags each channel whose voltage is under the done threshold.
// Assumes the bench sets one 8-bit voltage per channel, in the threshold's units.
`timescale 1ns/10ps
module cbpsc_uv_model (
    input  wire logic [7:0]  threshold,
    input  wire logic [47:0] cell_volt,
    output logic      [5:0]  below
);
    // A zero threshold disables the voltage stop, so no flag can rise then
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            below[i] = (threshold != 8'h00) && (cell_volt[i*8 +: 8] < threshold);
        end
    end
endmodule

// [bench/cbpsc_top_test.sv]
// Self-checking bench for the balancing pause/stop control, driven over its Avalon-MM port.
// Assumes a short timer step (TICK_CYC 10) so whole balancing runs finish quickly.
`timescale 1ns/10ps
module cbpsc_top_test;
    import cbpsc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        die_temp_hot = 1'b0;
    logic        fault_unmasked = 1'b0;
    logic        thermistor_hot = 1'b0;
    logic [5:0]  below;
    logic [5:0]  balance_switch;
    logic [7:0]  thr;
    logic [47:0] cell_volt = 48'hFFFF_FFFF_FFFF;
    logic [1:0]  power_mode_request;
    logic        power_mode_strobe;
    logic [3:0]  ot_thr;
    logic [31:0] r;
    logic [31:0] r1;
    int          errors = 0;
    int          cmp_count = 0;
    int          strobe_count = 0;

    always #2.5 clk_sys = ~clk_sys;

    cbpsc_top #(.TICK_CYC(10)) i_cbpsc_top (
        .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .die_temp_hot(die_temp_hot), .thermistor_hot(thermistor_hot),
        .fault_unmasked(fault_unmasked), .cell_below_done(below), .balance_switch(balance_switch),
        .done_voltage_threshold(thr), .thermistor_pause_threshold(ot_thr),
        .power_mode_request(power_mode_request), .power_mode_strobe(power_mode_strobe));
    cbpsc_uv_model i_cbpsc_uv_model (.threshold(thr), .cell_volt(cell_volt), .below(below));

    // Count completion strobes; each one is a single cycle, so a poll could miss it
    always @(posedge clk_sys) begin
        if (power_mode_strobe === 1'b1) begin
            strobe_count <= strobe_count + 1;
        end
    end

    // Verdict in one place; a spent wait also lands here
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One bus cycle: hold the request until waitrequest is seen low, then release
    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            errors++;
            end_sim();
        end
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // Poll status until the complete flag shows, bounded
    task automatic wait_done();
        int n;
        n = 0;
        r = 32'h0000_0000;
        while (r[2] !== 1'b1 && n < 100) begin
            bus(1'b0, ADDR_STAT, 16'h0000, r);
            n++;
        end
        if (n >= 100) begin
            errors++;
            end_sim();
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // Nothing started yet: result holds the invalid code
        bus(1'b0, ADDR_RESULT, 16'h0000, r); chk("result idle", r, 32'h0000_00FF);
        wr(ADDR_OT_THR, 16'h0009);
        chk("ot threshold", ot_thr, 32'h0000_0009);
        wr(ADDR_CTRL, 16'h0001);
        bus(1'b0, ADDR_STAT, 16'h0000, r); chk("stat zero go", r[3:0], 32'h0000_0000);
        wr(6'h20, 16'h0003);
        wr(6'h24, 16'h0005);
        wr(ADDR_CTRL, 16'h0029);
        repeat (3) @(posedge clk_sys);
        chk("switch run", balance_switch, 32'h0000_0003);
        // Host pause with a fault raised meanwhile: no abort may follow
        wr(ADDR_CTRL, 16'h002A);
        repeat (2) @(posedge clk_sys);
        chk("switch pause", balance_switch, 32'h0000_0000);
        fault_unmasked <= 1'b1;
        repeat (10) @(posedge clk_sys);
        bus(1'b0, ADDR_STAT, 16'h0000, r); chk("stat pause", r[3:0], 32'h0000_0002);
        fault_unmasked <= 1'b0;
        repeat (8) @(posedge clk_sys);
        wr(ADDR_CTRL, 16'h112A);
        bus(1'b0, ADDR_RESULT, 16'h0000, r1);
        chk("paused time", r1, 32'h0000_0005);
        repeat (40) @(posedge clk_sys);
        wr(ADDR_CTRL, 16'h112A);
        bus(1'b0, ADDR_RESULT, 16'h0000, r); chk("frozen time", r, r1);
        wr(ADDR_CTRL, 16'h0028);
        repeat (3) @(posedge clk_sys);
        chk("switch resume", balance_switch, 32'h0000_0003);
        wait_done(); chk("stat done", r[3:0], 32'h0000_0004);
        chk("power mode", power_mode_request, 32'h0000_0002);
        wr(ADDR_CTRL, 16'h0128);
        bus(1'b0, ADDR_RESULT, 16'h0000, r); chk("expired time", r, 32'h0000_0000);
        // Threshold above every cell: start then stop at once, time kept
        cell_volt <= 48'h4040_4040_4040;
        wr(ADDR_DONE, 16'h0080);
        wr(ADDR_CTRL, 16'h0001);
        wait_done(); chk("stat quick done", r[3:0], 32'h0000_0004);
        wr(ADDR_CTRL, 16'h1100);
        bus(1'b0, ADDR_RESULT, 16'h0000, r); chk("left time", r, 32'h0000_0005);
        // Die overheat, then enabled thermistor overheat pause; then a fault aborts everything
        wr(ADDR_DONE, 16'h0000);
        repeat (6) @(posedge clk_sys);
        wr(ADDR_CTRL, 16'h000D);
        repeat (3) @(posedge clk_sys);
        die_temp_hot <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("switch hot", balance_switch, 32'h0000_0000);
        die_temp_hot <= 1'b0;
        repeat (8) @(posedge clk_sys);
        thermistor_hot <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("switch ot", balance_switch, 32'h0000_0000);
        thermistor_hot <= 1'b0;
        repeat (8) @(posedge clk_sys);
        fault_unmasked <= 1'b1;
        repeat (8) @(posedge clk_sys);
        bus(1'b0, ADDR_STAT, 16'h0000, r); chk("stat abort", r[3:2], 32'h0000_0002);
        chk("switch abort", balance_switch, 32'h0000_0000);
        // Zeroed times then go: nothing runs and a later latch shows the invalid code
        wr(6'h20, 16'h0000);
        wr(6'h24, 16'h0000);
        wr(ADDR_CTRL, 16'h0001);
        bus(1'b0, ADDR_STAT, 16'h0000, r); chk("stat zero again", r[3:0], 32'h0000_0000);
        wr(ADDR_CTRL, 16'h1100);
        bus(1'b0, ADDR_RESULT, 16'h0000, r); chk("result zero go", r, 32'h0000_00FF);
        chk("power strobes", strobe_count, 32'h0000_0002);
        end_sim();
    end
endmodule
